// ===== pkg/gwac_cfg.svh
// Constants for the frame memory window address counter
`ifndef GWAC_CFG_SVH
`define GWAC_CFG_SVH
`define GWAC_COLS 240
`define GWAC_PAGES 320
`define GWAC_COL_LAST 9'h0EF
`define GWAC_PAGE_LAST 9'h13F
`define GWAC_PIX_W 18
`define GWAC_CMD_PARTIAL 8'h12
`define GWAC_CMD_SCRL_DEF 8'h33
`define GWAC_CMD_SCRL_START 8'h37
`define GWAC_RGB_MODE_GATED 2'h2
`define GWAC_A_COL_START 4'h0
`define GWAC_A_COL_END 4'h1
`define GWAC_A_PAGE_START 4'h2
`define GWAC_A_PAGE_END 4'h3
`define GWAC_A_ACCESS 4'h4
`define GWAC_A_PART_START 4'h5
`define GWAC_A_PART_END 4'h6
`define GWAC_A_TOP_FIXED 4'h7
`define GWAC_A_SCRL_AREA 4'h8
`define GWAC_A_BOT_FIXED 4'h9
`define GWAC_A_SCRL_START 4'hA
`define GWAC_A_MODE 4'hB
`define GWAC_A_STATUS 4'hC
`define GWAC_A_CMD 4'hD
`define GWAC_B_ROW_INV 7
`define GWAC_B_COL_INV 6
`define GWAC_B_AXIS_X 5
`define GWAC_B_VREF 4
`define GWAC_B_COLOUR 3
`define GWAC_B_GATE_REV 2
`define GWAC_B_SRC_REV 1
`endif

// ===== pkg/gwac_pkg.sv
// Types for the frame memory window address counter
package gwac_pkg;
  typedef enum logic [1:0] {
    GWAC_NORMAL = 2'h0,
    GWAC_PARTIAL = 2'h1,
    GWAC_SCROLL = 2'h3
  } gwac_disp_e;
  typedef logic [8:0] gwac_coord_t;
endpackage

// ===== logic/gwac_core.sv
// Window address counter, memory, scan mapping and RGB pixel counters
// Notes on behaviour
// [R1] Frame memory 240 columns by 320 pages, 18-bit
// [R2] Host and scan access anytime, no disturbance
// [R3] Pixel addressed by page and column pair
// [R4] Access command loads start column and page
// [R5] Each pixel advances column, page unchanged
// [R6] Past end column: reload column, page plus one
// [R7] Past end page: reload column and page
// [R8] Invert bits map to 239 or 319 minus value
// [R9] Axis exchange swaps column and page pointers
// [R10] Source reverse flips column to source order
// [R11] Gate reverse flips page to gate order
// [R12] Colour bit swaps red and blue channels
// [R13] Normal mode shows whole memory, origin top-left
// [R14] Command 12h enters partial rows, refresh order
// [R15] Scroll start command enables vertical scroll
// [R16] Host keeps fixed plus scroll lines at 320
// [R17] RGB mode update order from invert bits
// [R18] Vertical sync clears both pixel counters
// [R19] Active pixel advances horizontal counter only
// [R20] Horizontal sync: clear horizontal, vertical plus one; code does so only if a pixel was taken since the last sync
// [R21] Past last pixel returns to start corner
// [R22] Data-enable mode takes pixels only when enabled
// [R23] Host keeps window start not above end
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "gwac_cfg.svh"
module gwac_core #(
  parameter int COLS = `GWAC_COLS,
  parameter int PAGES = `GWAC_PAGES
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [17:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [17:0] o_rdata,
  input wire logic i_pix_wr,
  input wire logic [17:0] i_pix_data,
  input wire logic i_pix_rd,
  output logic [17:0] o_pix_rdata,
  input wire logic i_dot_en,
  input wire logic i_vsync,
  input wire logic i_hsync,
  input wire logic i_pixel_data_enable,
  input wire logic [17:0] i_rgb_data,
  input wire logic i_scan_en,
  input wire logic [8:0] i_scan_line,
  input wire logic [7:0] i_scan_col,
  output logic [17:0] o_scan_pixel,
  output logic [7:0] o_source_index,
  output logic [8:0] o_gate_index,
  output logic o_line_visible,
  output logic [8:0] o_col_ptr,
  output logic [8:0] o_page_ptr
);
  localparam logic [8:0] CL = `GWAC_COL_LAST;
  localparam logic [8:0] PL = `GWAC_PAGE_LAST;

  typedef struct packed {
    logic [8:0] window_start_column;
    logic [8:0] window_end_column;
    logic [8:0] window_start_page;
    logic [8:0] window_end_page;
    logic [7:0] memory_access_control;
    logic [8:0] partial_start_row;
    logic [8:0] partial_end_row;
    logic [8:0] top_fixed_lines;
    logic [8:0] scroll_area_lines;
    logic [8:0] bottom_fixed_lines;
    logic [8:0] scroll_start_line;
    logic [1:0] rgb_sync_mode_select;
    gwac_pkg::gwac_disp_e disp;
    logic [8:0] col;
    logic [8:0] page;
    logic [8:0] hcnt;
    logic [8:0] vcnt;
    logic line_seen;
    logic [17:0] rdata;
    logic [17:0] pix_rdata;
    logic rd_pend;
    logic [17:0] scan_pixel;
    logic [7:0] src_idx;
    logic [8:0] gate_idx;
    logic vis;
  } gwac_state_s;

  gwac_state_s s_q;
  gwac_state_s s_d;

  // Frame memory; separate host and scan ports avoid any access conflict
  logic [17:0] mem [COLS*PAGES]; // R1 R2

  function automatic logic [16:0] mem_index(input logic [8:0] c,
                                            input logic [8:0] p);
    logic [16:0] r;
    r = 17'(p) * 17'(COLS) + 17'(c); // R3
    return r;
  endfunction

  // Logical window position to physical memory column and page
  function automatic logic [17:0] phys_map(input logic [8:0] c,
                                           input logic [8:0] p,
                                           input logic [7:0] mac);
    logic [8:0] lc;
    logic [8:0] lp;
    lc = mac[`GWAC_B_AXIS_X] ? p : c; // R9
    lp = mac[`GWAC_B_AXIS_X] ? c : p; // R9
    if (mac[`GWAC_B_COL_INV])
      lc = CL - lc; // R8
    if (mac[`GWAC_B_ROW_INV])
      lp = PL - lp; // R8
    return {lc, lp};
  endfunction

  logic [8:0] mac_col;
  logic [8:0] mac_page;
  logic [8:0] rgb_col;
  logic [8:0] rgb_page;
  logic [8:0] mem_line;
  logic [8:0] sum_line;
  logic host_act;
  logic rgb_act;
  logic rgb_take;
  logic [7:0] mac;

  assign mac = s_q.memory_access_control;
  assign host_act = i_pix_wr | i_pix_rd;
  assign {mac_col, mac_page} = phys_map(s_q.col, s_q.page, mac);
  // Streaming ignores axis exchange: only the invert bits steer it
  assign {rgb_col, rgb_page} = phys_map(s_q.hcnt, s_q.vcnt,
                                        mac & 8'hDF); // R17
  assign rgb_act = s_q.rgb_sync_mode_select[1];
  assign rgb_take = rgb_act & i_dot_en & ~i_vsync & ~i_hsync
    & (s_q.rgb_sync_mode_select != `GWAC_RGB_MODE_GATED
       | i_pixel_data_enable); // R22

  // Scroll: lines in the scroll area are rotated by the start line
  always_comb
  begin
    sum_line = i_scan_line;
    mem_line = i_scan_line;
    if (s_q.disp == gwac_pkg::GWAC_SCROLL &&
        i_scan_line >= s_q.top_fixed_lines &&
        i_scan_line < PL + 9'h001 - s_q.bottom_fixed_lines)
    begin
      sum_line = i_scan_line - s_q.top_fixed_lines + s_q.scroll_start_line;
      if (sum_line >= s_q.top_fixed_lines + s_q.scroll_area_lines)
        mem_line = sum_line - s_q.scroll_area_lines; // R15 R16
      else
        mem_line = sum_line; // R15
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (host_act && i_pix_wr)
      mem[mem_index(mac_col, mac_page)] <= i_pix_data; // R2
    else if (rgb_take && rgb_col <= CL && rgb_page <= PL)
      mem[mem_index(rgb_col, rgb_page)] <= i_rgb_data; // R17
  end

  logic [17:0] host_word;
  logic [17:0] scan_word;
  always_ff @(posedge i_mclk)
  begin
    host_word <= mem[mem_index(mac_col, mac_page)];
    scan_word <= mem[mem_index({1'b0, i_scan_col}, mem_line)]; // R2
  end

  always_comb
  begin
    s_d = s_q;
    if (i_wr)
    begin
      unique case (i_addr)
        `GWAC_A_COL_START: s_d.window_start_column = i_wdata[8:0];
        `GWAC_A_COL_END: s_d.window_end_column = i_wdata[8:0];
        `GWAC_A_PAGE_START: s_d.window_start_page = i_wdata[8:0];
        `GWAC_A_PAGE_END: s_d.window_end_page = i_wdata[8:0];
        `GWAC_A_ACCESS: s_d.memory_access_control = i_wdata[7:0];
        `GWAC_A_PART_START: s_d.partial_start_row = i_wdata[8:0];
        `GWAC_A_PART_END: s_d.partial_end_row = i_wdata[8:0];
        `GWAC_A_TOP_FIXED: s_d.top_fixed_lines = i_wdata[8:0];
        `GWAC_A_SCRL_AREA: s_d.scroll_area_lines = i_wdata[8:0];
        `GWAC_A_BOT_FIXED: s_d.bottom_fixed_lines = i_wdata[8:0];
        `GWAC_A_SCRL_START:
        begin
          s_d.scroll_start_line = i_wdata[8:0];
          s_d.disp = gwac_pkg::GWAC_SCROLL; // R15
        end
        `GWAC_A_MODE: s_d.rgb_sync_mode_select = i_wdata[1:0];
        `GWAC_A_CMD:
        begin
          if (i_wdata[7:0] == `GWAC_CMD_PARTIAL)
            s_d.disp = gwac_pkg::GWAC_PARTIAL; // R14
          else if (i_wdata[7:0] == 8'h13)
            s_d.disp = gwac_pkg::GWAC_NORMAL; // R13
          else if (i_wdata[7:0] == 8'h2C || i_wdata[7:0] == 8'h2E)
          begin
            s_d.col = s_q.window_start_column; // R4
            s_d.page = s_q.window_start_page; // R4
          end
        end
        default: ;
      endcase
    end
    s_d.rdata = 18'h00000;
    if (i_rd)
    begin
      unique case (i_addr)
        `GWAC_A_COL_START: s_d.rdata = 18'(s_q.window_start_column);
        `GWAC_A_COL_END: s_d.rdata = 18'(s_q.window_end_column);
        `GWAC_A_PAGE_START: s_d.rdata = 18'(s_q.window_start_page);
        `GWAC_A_PAGE_END: s_d.rdata = 18'(s_q.window_end_page);
        `GWAC_A_ACCESS: s_d.rdata = 18'(mac);
        `GWAC_A_MODE: s_d.rdata = 18'(s_q.rgb_sync_mode_select);
        `GWAC_A_STATUS: s_d.rdata = {s_q.disp, 7'h00, s_q.page};
        `GWAC_A_CMD: s_d.rdata = {s_q.hcnt, s_q.col};
        default: s_d.rdata = 18'h00000;
      endcase
    end
    // Pixel access steps the window counter
    if (host_act && !(i_wr && i_addr == `GWAC_A_CMD))
    begin
      if (s_q.col >= s_q.window_end_column)
      begin
        s_d.col = s_q.window_start_column; // R6
        if (s_q.page >= s_q.window_end_page)
          s_d.page = s_q.window_start_page; // R7
        else
          s_d.page = s_q.page + 9'h001; // R6
      end
      else
        s_d.col = s_q.col + 9'h001; // R5
    end
    // RGB streaming pixel counters
    if (rgb_act && i_dot_en)
    begin
      if (i_vsync)
      begin
        s_d.hcnt = 9'h000; // R18
        s_d.vcnt = 9'h000; // R18
        s_d.line_seen = 1'b0;
      end
      else if (i_hsync)
      begin
        if (s_q.line_seen)
        begin
          s_d.hcnt = 9'h000; // R20
          s_d.vcnt = s_q.vcnt + 9'h001; // R20
        end
        s_d.line_seen = 1'b0;
      end
      else if (rgb_take)
      begin
        s_d.line_seen = 1'b1;
        if (s_q.hcnt >= CL && s_q.vcnt >= PL)
        begin
          s_d.hcnt = 9'h000; // R21
          s_d.vcnt = 9'h000; // R21
        end
        else
          s_d.hcnt = s_q.hcnt + 9'h001; // R19
      end
    end
    // The fetch at the read cycle's pointer lands one cycle later, so
    // back-to-back reads never return the previous pixel twice
    s_d.rd_pend = i_pix_rd;
    s_d.pix_rdata = s_q.rd_pend ? host_word : s_q.pix_rdata; // R5
    // Scan side mapping; pixel one cycle after memory fetch, indexes and visibility registered alongside the fetch
    if (i_scan_en)
    begin
      s_d.scan_pixel = mac[`GWAC_B_COLOUR] ?
        {scan_word[5:0], scan_word[11:6], scan_word[17:12]} :
        scan_word; // R12
      s_d.src_idx = mac[`GWAC_B_SRC_REV] ?
        8'(CL) - i_scan_col : i_scan_col; // R10
      s_d.gate_idx = mac[`GWAC_B_GATE_REV] ?
        PL - i_scan_line : i_scan_line; // R11
      s_d.vis = 1'b1; // R13
      if (s_q.disp == gwac_pkg::GWAC_PARTIAL)
        s_d.vis = mac[`GWAC_B_VREF] ?
          (PL - i_scan_line >= s_q.partial_start_row &&
           PL - i_scan_line <= s_q.partial_end_row) :
          (i_scan_line >= s_q.partial_start_row &&
           i_scan_line <= s_q.partial_end_row); // R14
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s_q <= '0;
      s_q.window_end_column <= CL;
      s_q.window_end_page <= PL;
      s_q.partial_end_row <= PL;
      s_q.scroll_area_lines <= 9'h140;
    end
    else
      s_q <= s_d;
  end

  assign o_rdata = s_q.rdata;
  assign o_pix_rdata = s_q.pix_rdata;
  assign o_scan_pixel = s_q.scan_pixel;
  assign o_source_index = s_q.src_idx;
  assign o_gate_index = s_q.gate_idx;
  assign o_line_visible = s_q.vis;
  assign o_col_ptr = mac_col;
  assign o_page_ptr = mac_page;

  AST_COL_STEP: assert property (@(posedge i_mclk) // R5
    disable iff (!i_rst_b)
    host_act && !i_wr && s_q.col < s_q.window_end_column
    |=> s_q.col == $past(s_q.col) + 9'h001 && $stable(s_q.page))
    else $error("column did not step");
  AST_COL_WRAP: assert property (@(posedge i_mclk) // R6
    disable iff (!i_rst_b)
    host_act && !i_wr && s_q.col >= s_q.window_end_column
    && s_q.page < s_q.window_end_page
    |=> s_q.col == s_q.window_start_column
    && s_q.page == $past(s_q.page) + 9'h001)
    else $error("column wrap wrong");
  AST_PAGE_WRAP: assert property (@(posedge i_mclk) // R7
    disable iff (!i_rst_b)
    host_act && !i_wr && s_q.col >= s_q.window_end_column
    && s_q.page >= s_q.window_end_page
    |=> s_q.page == s_q.window_start_page)
    else $error("page wrap wrong");
  AST_LOAD: assert property (@(posedge i_mclk) // R4
    disable iff (!i_rst_b)
    i_wr && i_addr == `GWAC_A_CMD && i_wdata[7:0] == 8'h2C
    |=> s_q.col == $past(s_q.window_start_column))
    else $error("start not loaded");
  AST_INVERT: assert property (@(posedge i_mclk) // R8
    disable iff (!i_rst_b)
    !mac[`GWAC_B_AXIS_X] && mac[`GWAC_B_COL_INV]
    |-> o_col_ptr == CL - s_q.col)
    else $error("column invert wrong");
  AST_SWAP: assert property (@(posedge i_mclk) // R9
    disable iff (!i_rst_b)
    mac[`GWAC_B_AXIS_X] && !mac[`GWAC_B_ROW_INV]
    |-> o_page_ptr == s_q.col)
    else $error("axis exchange wrong");
  AST_VSYNC: assert property (@(posedge i_mclk) // R18
    disable iff (!i_rst_b)
    rgb_act && i_dot_en && i_vsync |=> s_q.hcnt == 9'h000
    && s_q.vcnt == 9'h000)
    else $error("vsync clear missed");
  AST_ENABLE_GATE: assert property (@(posedge i_mclk) // R22
    disable iff (!i_rst_b)
    s_q.rgb_sync_mode_select == `GWAC_RGB_MODE_GATED && !i_pixel_data_enable
    && !i_vsync && !i_hsync |=> $stable(s_q.hcnt))
    else $error("pixel taken without enable");
  AST_GATE_REV: assert property (@(posedge i_mclk) // R11
    disable iff (!i_rst_b)
    i_scan_en && mac[`GWAC_B_GATE_REV] |=>
    o_gate_index == PL - $past(i_scan_line))
    else $error("gate reverse wrong");
endmodule

// ===== sim/gwac_rgb_src.sv
// Behavioural RGB graphics controller feeding the dot-clock pixel stream
`timescale 1ns/1ns
module gwac_rgb_src (
  input wire logic i_mclk,
  output logic o_dot_en,
  output logic o_vsync,
  output logic o_hsync,
  output logic o_pixel_data_enable,
  output logic [17:0] o_data
);
  initial
  begin
    o_dot_en = 1'b0;
    o_vsync = 1'b0;
    o_hsync = 1'b0;
    o_pixel_data_enable = 1'b0;
    o_data = 18'h00000;
  end

  // One dot event; the data line shows the inverse once released, so a
  // stale word can never pass for a fresh pixel
  task automatic dot(input logic vs, input logic hs, input logic en,
    input logic [17:0] d);
    @(posedge i_mclk);
    o_dot_en <= 1'b1;
    o_vsync <= vs;
    o_hsync <= hs;
    o_pixel_data_enable <= en;
    o_data <= d;
    @(posedge i_mclk);
    o_dot_en <= 1'b0;
    o_vsync <= 1'b0;
    o_hsync <= 1'b0;
    o_pixel_data_enable <= 1'b0;
    o_data <= ~d;
  endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the frame memory window address counter
`timescale 1ns/1ns
`include "gwac_cfg.svh"
module tb;
  localparam logic [17:0] PX = 18'h2A5C3;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [17:0] i_wdata = 18'h00000;
  logic [17:0] i_pix_data = 18'h00000;
  logic i_wr = 1'b0, i_rd = 1'b0, i_pix_wr = 1'b0, i_pix_rd = 1'b0;
  logic i_scan_en = 1'b0;
  logic [8:0] i_scan_line = 9'h000;
  logic [7:0] i_scan_col = 8'h00;
  logic i_dot_en, i_vsync, i_hsync, i_pixel_data_enable;
  logic [17:0] i_rgb_data, o_rdata, o_pix_rdata, o_scan_pixel, q;
  logic [7:0] o_source_index;
  logic [8:0] o_gate_index, o_col_ptr, o_page_ptr;
  logic o_line_visible;
  int err_count = 0;
  int compares = 0;

  always #5 i_mclk = ~i_mclk;

  gwac_core i_gwac_core (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_pix_wr(i_pix_wr), .i_pix_data(i_pix_data),
    .i_pix_rd(i_pix_rd), .o_pix_rdata(o_pix_rdata), .i_dot_en(i_dot_en),
    .i_vsync(i_vsync), .i_hsync(i_hsync),
    .i_pixel_data_enable(i_pixel_data_enable), .i_rgb_data(i_rgb_data),
    .i_scan_en(i_scan_en), .i_scan_line(i_scan_line),
    .i_scan_col(i_scan_col), .o_scan_pixel(o_scan_pixel),
    .o_source_index(o_source_index), .o_gate_index(o_gate_index),
    .o_line_visible(o_line_visible), .o_col_ptr(o_col_ptr),
    .o_page_ptr(o_page_ptr));

  gwac_rgb_src i_gwac_rgb_src (.i_mclk(i_mclk), .o_dot_en(i_dot_en),
    .o_vsync(i_vsync), .o_hsync(i_hsync),
    .o_pixel_data_enable(i_pixel_data_enable),
    .o_data(i_rgb_data));

  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [17:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    // Let the registers settle before any caller looks at the pointers
    #1;
  endtask

  // Read data stands for one cycle only, so the idle zero is checked too
  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
    @(posedge i_mclk);
    #1;
    chk(o_rdata, 18'h00000);
  endtask

  task automatic mode(input gwac_pkg::gwac_disp_e m);
    rd(`GWAC_A_STATUS);
    chk(18'(q[17:16]), 18'(m));
  endtask

  task automatic ptr(input logic [8:0] c, input logic [8:0] p);
    chk(18'(o_col_ptr), 18'(c));
    chk(18'(o_page_ptr), 18'(p));
  endtask

  task automatic win(input logic [8:0] c0, input logic [8:0] c1,
    input logic [8:0] p0, input logic [8:0] p1);
    wr(`GWAC_A_COL_START, 18'(c0));
    wr(`GWAC_A_COL_END, 18'(c1));
    wr(`GWAC_A_PAGE_START, 18'(p0));
    wr(`GWAC_A_PAGE_END, 18'(p1));
    wr(`GWAC_A_CMD, 18'h0002C);
  endtask

  task automatic acc(input logic [17:0] bits);
    wr(`GWAC_A_ACCESS, bits);
    wr(`GWAC_A_CMD, 18'h0002C);
  endtask

  task automatic pw(input logic [17:0] d);
    @(posedge i_mclk);
    i_pix_data <= d;
    i_pix_wr <= 1'b1;
    @(posedge i_mclk);
    i_pix_wr <= 1'b0;
    #1;
  endtask

  task automatic pr(input logic [17:0] exp);
    @(posedge i_mclk);
    i_pix_rd <= 1'b1;
    @(posedge i_mclk);
    i_pix_rd <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_pix_rdata, exp);
  endtask

  // The scan position is held, so every scan output has settled
  task automatic scan(input logic [8:0] l, input logic [7:0] c);
    @(posedge i_mclk);
    i_scan_en <= 1'b1;
    i_scan_line <= l;
    i_scan_col <= c;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask

  task automatic vis(input logic [8:0] l, input logic e);
    scan(l, 8'h00);
    chk(18'(o_line_visible), 18'(e));
  endtask

  task automatic t_reset();
    ptr(9'h000, 9'h000);
    mode(gwac_pkg::GWAC_NORMAL);
    rd(`GWAC_A_COL_END);
    chk(q, 18'(`GWAC_COL_LAST));
    rd(`GWAC_A_PAGE_END);
    chk(q, 18'(`GWAC_PAGE_LAST));
    wr(4'hE, 18'h3FFFF);
    rd(4'hE);
    chk(q, 18'h00000);
  endtask

  task automatic t_window();
    win(9'h002, 9'h003, 9'h005, 9'h006);
    ptr(9'h002, 9'h005);
    pw(18'h01001);
    ptr(9'h003, 9'h005);
    pw(18'h01002);
    ptr(9'h002, 9'h006);
    pw(18'h01003);
    pw(18'h01004);
    ptr(9'h002, 9'h005);
    acc(18'h1 << `GWAC_B_COL_INV);
    ptr(9'h0ED, 9'h005);
    acc(18'h1 << `GWAC_B_ROW_INV);
    ptr(9'h002, 9'h13A);
    acc(18'h1 << `GWAC_B_AXIS_X);
    ptr(9'h005, 9'h002);
  endtask

  task automatic t_memory();
    acc(18'h00000);
    win(9'h0EF, 9'h0EF, 9'h13F, 9'h13F);
    pw(PX);
    scan(9'h13F, 8'hEF);
    pr(PX);
    chk(o_scan_pixel, PX);
    chk(18'(o_source_index), 18'h000EF);
    chk(18'(o_gate_index), 18'h0013F);
    acc((18'h1 << `GWAC_B_SRC_REV) | (18'h1 << `GWAC_B_GATE_REV)
      | (18'h1 << `GWAC_B_COLOUR));
    chk(18'(o_source_index), 18'h00000);
    chk(18'(o_gate_index), 18'h00000);
    chk(o_scan_pixel, {PX[5:0], PX[11:6], PX[17:12]});
  endtask

  task automatic t_regions();
    acc(18'h00000);
    wr(`GWAC_A_PART_START, 18'h00032);
    wr(`GWAC_A_PART_END, 18'h00096);
    wr(`GWAC_A_CMD, 18'(`GWAC_CMD_PARTIAL));
    mode(gwac_pkg::GWAC_PARTIAL);
    vis(9'h031, 1'b0);
    vis(9'h032, 1'b1);
    vis(9'h096, 1'b1);
    vis(9'h097, 1'b0);
    acc(18'h1 << `GWAC_B_VREF);
    vis(9'h10D, 1'b1);
    vis(9'h032, 1'b0);
    win(9'h000, 9'h000, 9'h003, 9'h003);
    pw(18'h0C3A5);
    win(9'h000, 9'h000, 9'h000, 9'h000);
    pw(18'h15A3C);
    wr(`GWAC_A_TOP_FIXED, 18'h00002);
    wr(`GWAC_A_SCRL_AREA, 18'h0013E);
    wr(`GWAC_A_BOT_FIXED, 18'h00000);
    wr(`GWAC_A_SCRL_START, 18'h00003);
    mode(gwac_pkg::GWAC_SCROLL);
    scan(9'h002, 8'h00);
    chk(o_scan_pixel, 18'h0C3A5);
    scan(9'h000, 8'h00);
    chk(o_scan_pixel, 18'h15A3C);
    wr(`GWAC_A_CMD, 18'h00013);
    mode(gwac_pkg::GWAC_NORMAL);
    vis(9'h031, 1'b1);
  endtask

  task automatic t_stream();
    wr(`GWAC_A_MODE, 18'(`GWAC_RGB_MODE_GATED));
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b1, 18'h3FFFF);
    i_gwac_rgb_src.dot(1'b1, 1'b0, 1'b0, 18'h00000);
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b1, 18'h11111);
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b0, 18'h2EEEE);
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b1, 18'h22222);
    i_gwac_rgb_src.dot(1'b0, 1'b1, 1'b0, 18'h00000);
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b1, 18'h33333);
    acc(18'h1 << `GWAC_B_COL_INV);
    i_gwac_rgb_src.dot(1'b1, 1'b0, 1'b0, 18'h00000);
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b1, 18'h0ABCD);
    wr(`GWAC_A_MODE, 18'h00003);
    i_gwac_rgb_src.dot(1'b0, 1'b0, 1'b0, 18'h1BCDE);
    wr(`GWAC_A_MODE, 18'h00000);
    acc(18'h00000);
    win(9'h000, 9'h001, 9'h000, 9'h001);
    pr(18'h11111);
    pr(18'h22222);
    pr(18'h33333);
    wr(`GWAC_A_CMD, 18'h0002E);
    pr(18'h11111);
    win(9'h0EE, 9'h0EF, 9'h000, 9'h000);
    pr(18'h1BCDE);
    pr(18'h0ABCD);
  endtask

  // The whole sequence needs about 250 cycles; the limit allows for 10000
  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_reset();
    t_window();
    t_memory();
    t_regions();
    t_stream();
    complete_run();
  end
endmodule
